/* hw/lrsd_ctrl.sv */
// Line rate and scan direction controller: trigger timing, rate cap,
// direction source and per-row spacing tags for the frame grabber.
// Assumes inputs synchronous to core_clk and an Avalon-MM register master.
// How it works
// - Triggers from any origin are counted per 1 ms window and read back in kHz.
// - Standard parts cap at 300 kHz; dual-range outputs two rows at 150 kHz.
// - High-speed parts cap by window, depth and grabbers, at most 400 kHz.
// - Multicolor parts allow higher rates as fewer color arrays are output.
// - Triggers faster than the cap are dropped; the next trigger past the least period is output.
// - Internal origin triggers from a timer with a programmable period.
// - Direction from internal setting, a direction line or the wheel decoder.
// - Wheel direction only with wheel trigger origin and motion output.
// - Internal source uses the software direction setting.
// - A direction change completes well within 1 ms.
// - Every output row carries a row spacing tag for the grabber.
// - Dual-array offset is 163 or 99 rows, chosen by current direction.
// - Spatial correction is off for single-array output.
// - Rows of several arrays leave one array after another, planar order.
`timescale 1ns/100ps
`default_nettype none
module lrsd_ctrl #(
    parameter int MEAS_WIN_CYC = lrsd_pkg::MEAS_WINDOW_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trig_pin_in,
    input wire logic link_trig_in,
    input wire logic wheel_step_in,
    input wire logic wheel_dir_in,
    input wire logic dir_line_in,
    output logic line_trigger,
    output logic scan_reverse,
    output logic row_valid,
    input wire logic row_ready,
    output logic [lrsd_pkg::TAG_W-1:0] row_tag
);
    import lrsd_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_EMIT} lrsd_state_t;

    lrsd_state_t state_q;
    logic [31:0] ctrl_q;
    logic [31:0] mode_q;
    logic [31:0] period_q;
    logic ack_q;
    logic pin_prev_q;
    logic [19:0] timer_q;
    logic [11:0] gap_q;
    logic [15:0] win_q;
    logic [15:0] win_trig_q;
    logic [15:0] meas_q;
    logic [15:0] drops_q;
    logic [15:0] line_q;
    logic [1:0] row_idx_q;
    logic dir_q;
    logic [1:0] origin;
    logic [1:0] dir_src;
    logic wheel_ok;
    logic src_fault;
    logic dir_sel;
    logic pin_edge;
    logic timer_hit;
    logic trig;
    logic accept;
    logic [21:0] cap;
    logic [1:0] nrows;
    logic wr_hit;
    logic [9:0] offset;
    lrsd_row_if emit_if ();
    lrsd_row_if out_if ();

    // Merges a write into a register under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        be_merge = r;
    endfunction

    // Rate ceiling for the configured model and output mode
    function automatic logic [21:0] rate_cap(input logic [31:0] m);
        logic b12;
        logic two;
        b12 = m[MOD_BIT12];
        two = m[MOD_TWOFG];
        rate_cap = lim(LIM_STD_KHZ);
        case (m[MOD_CLASS +: 2])
            CLS_HIGHSPEED: begin
                if (m[MOD_ARRAYS +: 2] != ARR_SINGLE) rate_cap = lim(LIM_HS_DUAL_KHZ);
                else case (m[MOD_WINDOW +: 2])
                    WIN_16K: rate_cap = b12 ? (two ? lim(LIM_HS16_12_2_KHZ) : lim(LIM_HS16_12_1_KHZ))
                                            : (two ? lim(LIM_ABS_KHZ) : lim(LIM_HS16_8_1_KHZ));
                    WIN_12K: rate_cap = (b12 && two) ? lim(LIM_HS12_12_2_KHZ)
                                      : b12 ? lim(LIM_HS12_12_1_KHZ) : lim(LIM_ABS_KHZ);
                    WIN_9K: rate_cap = (b12 && !two) ? lim(LIM_HS9_12_1_KHZ) : lim(LIM_ABS_KHZ);
                    default: rate_cap = lim(LIM_ABS_KHZ);
                endcase
            end
            CLS_MULTICOLOR: begin
                case (m[MOD_COLORS +: 2])
                    2'h3: rate_cap = b12 ? lim(LIM_MC3_12_KHZ) : lim(LIM_MC3_8_KHZ);
                    2'h2: rate_cap = b12 ? lim(LIM_MC2_12_KHZ) : lim(LIM_MC2_8_KHZ);
                    default: rate_cap = b12 ? lim(LIM_MC1_12_KHZ) : lim(LIM_ABS_KHZ);
                endcase
            end
            default: begin
                if (m[MOD_ARRAYS +: 2] != ARR_SINGLE) rate_cap = lim(LIM_STD_DUAL_KHZ);
            end
        endcase
    endfunction

    // Rows sent per accepted trigger, minus one
    function automatic logic [1:0] rows_m1(input logic [31:0] m);
        if (m[MOD_CLASS +: 2] == CLS_MULTICOLOR) begin
            rows_m1 = (m[MOD_COLORS +: 2] == 2'h0) ? 2'h0 : m[MOD_COLORS +: 2] - 2'h1;
        end else begin
            rows_m1 = (m[MOD_ARRAYS +: 2] == ARR_SINGLE) ? 2'h0 : 2'h1;
        end
    endfunction

    assign origin = ctrl_q[CTL_ORIGIN +: 2];
    assign dir_src = ctrl_q[CTL_DIRSRC +: 2];
    assign cap = rate_cap(mode_q);
    assign nrows = rows_m1(mode_q);

    // Direction source; the wheel counts only when it triggers in motion mode
    assign wheel_ok = (origin == ORG_WHEEL) && ctrl_q[CTL_WHEELOUT];
    assign src_fault = (dir_src == SRC_WHEEL) && !wheel_ok;
    always_comb begin
        dir_sel = ctrl_q[CTL_DIRSET];
        if (dir_src == SRC_LINE) dir_sel = dir_line_in;
        else if (dir_src == SRC_WHEEL && wheel_ok) dir_sel = wheel_dir_in;
    end

    // Trigger origin and edge selection
    always_comb begin
        case (ctrl_q[CTL_ACTIV +: 2])
            ACT_RISE: pin_edge = trig_pin_in & ~pin_prev_q;
            ACT_FALL: pin_edge = ~trig_pin_in & pin_prev_q;
            default: pin_edge = trig_pin_in ^ pin_prev_q;
        endcase
        case (origin)
            ORG_INTERNAL: trig = timer_hit;
            ORG_PIN: trig = pin_edge;
            ORG_LINK: trig = link_trig_in;
            default: trig = wheel_step_in;
        endcase
        trig = trig & ctrl_q[CTL_ENABLE];
    end

    // A trigger inside the least period, or while rows leave, is dropped
    assign accept = trig && (gap_q >= cap[11:0] - 12'h001) && (state_q == ST_IDLE);
    assign line_trigger = accept;
    assign timer_hit = (period_q[19:0] != 20'h00000) && (timer_q >= period_q[19:0] - 20'h00001);

    // Internal line timer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            timer_q <= '0;
        end else if (clk_en) begin
            timer_q <= timer_hit ? 20'h00000 : timer_q + 20'h00001;
        end
    end

    // Trigger spacing, saturating so a slow line rate never wraps
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            gap_q <= 12'hFFF;
            pin_prev_q <= 1'b0;
        end else if (clk_en) begin
            pin_prev_q <= trig_pin_in;
            if (accept) gap_q <= 12'h000;
            else if (gap_q != 12'hFFF) gap_q <= gap_q + 12'h001;
        end
    end

    // Rate measurement: triggers per millisecond equals kHz
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            win_q <= '0;
            win_trig_q <= '0;
            meas_q <= '0;
        end else if (clk_en) begin
            if (win_q == 16'(MEAS_WIN_CYC - 1)) begin
                win_q <= 16'h0000;
                meas_q <= win_trig_q + {15'h0000, trig};
                win_trig_q <= 16'h0000;
            end else begin
                win_q <= win_q + 16'h0001;
                win_trig_q <= win_trig_q + {15'h0000, trig};
            end
        end
    end

    // Drop counter; a drop in the clearing cycle still counts
    assign wr_hit = avs_write && ack_q && (avs_address == OFS_DROPS);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            drops_q <= '0;
        end else if (clk_en) begin
            if (trig && !accept) drops_q <= (wr_hit ? 16'h0000 : drops_q) + 16'h0001;
            else if (wr_hit) drops_q <= 16'h0000;
        end
    end

    // Direction is only taken between lines, a few cycles after a change
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            dir_q <= 1'b0;
        end else if (clk_en && state_q == ST_IDLE && !accept) begin
            dir_q <= dir_sel;
        end
    end
    assign scan_reverse = dir_q;

    // Row emitter: one tag per array, arrays in planar order
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            row_idx_q <= '0;
            line_q <= '0;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_EMIT;
                        row_idx_q <= 2'h0;
                        line_q <= line_q + 16'h0001;
                    end
                end
                ST_EMIT: begin
                    if (emit_if.ready) begin
                        if (row_idx_q == nrows) state_q <= ST_IDLE;
                        else row_idx_q <= row_idx_q + 2'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Offset grows per array; dual output gives 163 forward, 99 reverse
    always_comb begin
        offset = 10'h000;
        if (row_idx_q == 2'h1) offset = dir_q ? SPACE_REV : SPACE_FWD;
        else if (row_idx_q == 2'h2) offset = dir_q ? {SPACE_REV[8:0], 1'b0}
                                                   : {SPACE_FWD[8:0], 1'b0};
    end

    // Tag every row; spatial flag clear for single-array output
    always_comb begin
        emit_if.valid = (state_q == ST_EMIT);
        emit_if.data = '0;
        emit_if.data[TAG_LINE +: 16] = line_q;
        emit_if.data[TAG_NROWS +: 2] = nrows;
        emit_if.data[TAG_OFFSET +: 10] = offset;
        emit_if.data[TAG_SPATIAL] = (nrows != 2'h0);
        emit_if.data[TAG_ARRAY +: 2] = row_idx_q;
        emit_if.data[TAG_DIR] = dir_q;
    end

    lrsd_row_buf u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_if(emit_if),
        .out_if(out_if)
    );
    assign row_valid = out_if.valid;
    assign row_tag = out_if.data;
    assign out_if.ready = row_ready;

    // One wait state; a low clock enable keeps the wait
    assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & clk_en);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // Writable registers take effect at the accepting edge only
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
            mode_q <= MODE_RESET;
            period_q <= PERIOD_RESET;
        end else if (clk_en && avs_write && ack_q) begin
            case (avs_address)
                OFS_CTRL: ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
                OFS_MODE: mode_q <= be_merge(mode_q, avs_writedata, avs_byteenable);
                OFS_PERIOD: period_q <= be_merge(period_q, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
    end

    // Read data captured in the wait cycle; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_readdata <= '0;
        end else if (clk_en && avs_read && !ack_q) begin
            case (avs_address)
                OFS_CTRL: avs_readdata <= ctrl_q;
                OFS_MODE: avs_readdata <= mode_q;
                OFS_PERIOD: avs_readdata <= {12'h000, period_q[19:0]};
                OFS_MEAS: avs_readdata <= {16'h0000, meas_q};
                OFS_STATUS: avs_readdata <= {28'h0000000, src_fault, state_q == ST_EMIT,
                                             dir_sel != dir_q, dir_q};
                OFS_DROPS: avs_readdata <= {16'h0000, drops_q};
                OFS_LIMIT: avs_readdata <= {10'h000, cap};
                default: avs_readdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* hw/lrsd_pkg.sv */
// Package for the line rate and scan direction controller.
// Assumes one 25 MHz core clock and an Avalon-MM register port.
package lrsd_pkg;
    // Core clock rate in kHz; every cycle count below derives from it
    localparam int CLK_KHZ = 25000;
    localparam int MEAS_WINDOW_US = 1000;
    localparam int MEAS_WINDOW_CYC = CLK_KHZ * MEAS_WINDOW_US / 1000;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_MEAS = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_DROPS = 8'h14;
    localparam logic [7:0] OFS_LIMIT = 8'h18;
    // Control register fields
    localparam int CTL_ORIGIN = 0;
    localparam int CTL_ACTIV = 2;
    localparam int CTL_DIRSRC = 4;
    localparam int CTL_DIRSET = 6;
    localparam int CTL_WHEELOUT = 7;
    localparam int CTL_ENABLE = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
    // Mode register fields
    localparam int MOD_CLASS = 0;
    localparam int MOD_BIT12 = 2;
    localparam int MOD_ARRAYS = 3;
    localparam int MOD_COLORS = 5;
    localparam int MOD_WINDOW = 7;
    localparam int MOD_TWOFG = 9;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
    // Field codes
    localparam logic [1:0] ORG_INTERNAL = 2'h0;
    localparam logic [1:0] ORG_PIN = 2'h1;
    localparam logic [1:0] ORG_LINK = 2'h2;
    localparam logic [1:0] ORG_WHEEL = 2'h3;
    localparam logic [1:0] ACT_RISE = 2'h0;
    localparam logic [1:0] ACT_FALL = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_LINE = 2'h1;
    localparam logic [1:0] SRC_WHEEL = 2'h2;
    localparam logic [1:0] CLS_STANDARD = 2'h0;
    localparam logic [1:0] CLS_HIGHSPEED = 2'h1;
    localparam logic [1:0] CLS_MULTICOLOR = 2'h2;
    localparam logic [1:0] ARR_SINGLE = 2'h0;
    localparam logic [1:0] ARR_DUAL_RANGE = 2'h1;
    localparam logic [1:0] ARR_FULL_WELL = 2'h2;
    localparam logic [1:0] WIN_16K = 2'h0;
    localparam logic [1:0] WIN_12K = 2'h1;
    localparam logic [1:0] WIN_9K = 2'h2;
    // Line rate ceilings in kHz
    localparam int LIM_STD_KHZ = 300;
    localparam int LIM_STD_DUAL_KHZ = 150;
    localparam int LIM_HS_DUAL_KHZ = 200;
    localparam int LIM_ABS_KHZ = 400;
    localparam int LIM_HS16_12_1_KHZ = 205;
    localparam int LIM_HS16_12_2_KHZ = 275;
    localparam int LIM_HS16_8_1_KHZ = 360;
    localparam int LIM_HS12_12_1_KHZ = 275;
    localparam int LIM_HS12_12_2_KHZ = 368;
    localparam int LIM_HS9_12_1_KHZ = 367;
    localparam int LIM_MC3_8_KHZ = 133;
    localparam int LIM_MC2_8_KHZ = 200;
    localparam int LIM_MC3_12_KHZ = 88;
    localparam int LIM_MC2_12_KHZ = 133;
    localparam int LIM_MC1_12_KHZ = 266;
    // Main to secondary row spacing, per direction
    localparam logic [9:0] SPACE_FWD = 10'h0A3;
    localparam logic [9:0] SPACE_REV = 10'h063;
    // Row tag layout
    localparam int TAG_LINE = 0;
    localparam int TAG_NROWS = 16;
    localparam int TAG_OFFSET = 18;
    localparam int TAG_SPATIAL = 28;
    localparam int TAG_ARRAY = 29;
    localparam int TAG_DIR = 31;
    localparam int TAG_W = 32;

    // Packs a ceiling as {kHz, least trigger period in cycles, rounded up}
    function automatic logic [21:0] lim(input int khz);
        lim = {khz[9:0], 12'((CLK_KHZ + khz - 1) / khz)};
    endfunction
endpackage

/* hw/lrsd_row_buf.sv */
// Two-entry row tag buffer; the head flip-flop drives the output.
// Assumes a synchronous active-low reset; a low clock enable freezes it.
`timescale 1ns/100ps
`default_nettype none
module lrsd_row_buf (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    lrsd_row_if.snk in_if,
    lrsd_row_if.src out_if
);
    import lrsd_pkg::*;

    logic [TAG_W-1:0] head_q;
    logic [TAG_W-1:0] tail_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Ready drops only when both entries are full, stalling the emitter
    assign in_if.ready = (cnt_q != 2'h2);
    assign out_if.valid = (cnt_q != 2'h0);
    assign out_if.data = head_q;
    assign push = in_if.valid & in_if.ready;
    assign pop = out_if.valid & out_if.ready;

    // Occupancy
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q <= 2'h0;
        end else if (clk_en) begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Entry shifting: head always holds the oldest row
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            head_q <= '0;
            tail_q <= '0;
        end else if (clk_en) begin
            if (pop && cnt_q == 2'h2) begin
                head_q <= tail_q;
            end else if (push && (cnt_q == 2'h0 || pop)) begin
                head_q <= in_if.data;
            end
            if (push && cnt_q == 2'h1 && !pop) begin
                tail_q <= in_if.data;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/lrsd_row_if.sv */
// Row tag stream from the controller to its row buffer.
// Assumes both ends share the core clock.
`timescale 1ns/100ps
`default_nettype none
interface lrsd_row_if;
    logic valid;
    logic ready;
    logic [31:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* testbench/line_rate_scan_direction_ctrl_tb.sv */
// Self-checking bench for lrsd_ctrl with a frame grabber stand-in.
// Assumes the package and design compile first.
`timescale 1ns/100ps
`default_nettype none
module line_rate_scan_direction_ctrl_tb;
    import lrsd_pkg::*;
    // Mode words with ceilings; direction cases as {exp, wheel, line, ctrl}
    localparam logic [9:0] LM [9] = '{10'h000, 10'h008, 10'h001, 10'h201, 10'h285, 10'h009,
        10'h062, 10'h042, 10'h022};
    localparam int LK [9] = '{LIM_STD_KHZ, LIM_STD_DUAL_KHZ, LIM_HS16_8_1_KHZ, LIM_ABS_KHZ,
        LIM_HS12_12_2_KHZ, LIM_HS_DUAL_KHZ, LIM_MC3_8_KHZ, LIM_MC2_8_KHZ, LIM_ABS_KHZ};
    localparam logic [11:0] DT [9] = '{12'h940, 12'hB10, 12'h510, 12'h520, 12'h523,
        12'hDA3, 12'h1A3, 12'hD60, 12'h100};
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic dir_line_in = 1'b0;
    logic wheel_dir_in = 1'b0;
    logic slow = 1'b0;
    logic exp_dir = 1'b0;
    logic [1:0] nrows = 2'h0;
    logic [7:0] rnd = 8'h33;
    logic [31:0] q, e, e_row;
    logic [31:0] exp_rows [$];
    wire [31:0] avs_readdata, row_tag;
    wire avs_waitrequest, line_trigger, scan_reverse, row_valid, row_ready;
    int bad_count = 0;
    int compares = 0;
    int line_no = 0;
    int c;
    lrsd_ctrl #(.MEAS_WIN_CYC(100)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_pin_in(1'b0), .link_trig_in(rnd == 8'h33),
        .wheel_step_in(1'b0), .wheel_dir_in(wheel_dir_in), .dir_line_in(dir_line_in),
        .line_trigger(line_trigger), .scan_reverse(scan_reverse), .row_valid(row_valid),
        .row_ready(row_ready), .row_tag(row_tag));
    lrsd_fg_model u_fg (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
        .coin(rnd[0] | rnd[3]), .row_valid(row_valid), .row_tag(row_tag), .row_ready(row_ready));
    // 25 MHz clock; an 8-bit LFSR for stalls and link pulses
    always #20 core_clk = ~core_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    always @(posedge core_clk) rnd <= lfsr(rnd);
    // Reference rows per accepted trigger, checked at each take
    always @(negedge core_clk) begin
        if (reset_n && line_trigger === 1'b1) begin
            line_no++;
            for (int k = 0; k <= nrows; k++) begin
                exp_rows.push_back({exp_dir, 2'(k), nrows != 2'h0,
                    10'(k) * (exp_dir ? 10'h063 : 10'h0A3), nrows, 16'(line_no)});
            end
        end
        if (reset_n && row_valid === 1'b1 && row_ready === 1'b1) begin
            e_row = exp_rows.size() > 0 ? exp_rows.pop_front() : 32'hFFFF_FFFF;
            chk_row(row_tag, e_row);
        end
    end
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR t=%0t reg got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_row(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR t=%0t row got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic final_report();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        $display("ERROR t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    endtask
    // Avalon master: hold until waitrequest is low, then release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) hang();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk_reg(q, x);
    endtask
    // Direction settles within four cycles
    task automatic wait_dir(input logic x);
        repeat (4) @(negedge core_clk);
        chk_reg({31'h0, scan_reverse}, {31'h0, x});
    endtask
    task automatic gap(output int g);
        int n;
        @(negedge core_clk);
        for (n = 0; n < 2000 && line_trigger !== 1'b1; n++) @(negedge core_clk);
        @(negedge core_clk);
        for (g = 1; g < 2000 && line_trigger !== 1'b1; g++) @(negedge core_clk);
        if (n >= 2000 || g >= 2000) hang();
    endtask
    task automatic stop();
        int n;
        bus(1'b1, OFS_PERIOD, 32'h0);
        for (n = 0; n < 2000 && exp_rows.size() > 0; n++) @(negedge core_clk);
        if (n >= 2000) hang();
    endtask
    // Timer at 125 kHz with a stalling grabber, then drain
    task automatic run_rows(input logic [9:0] m, input logic [9:0] ct, input logic d, input int n);
        int k;
        bus(1'b1, OFS_MODE, {22'h0, m});
        bus(1'b1, OFS_CTRL, {22'h0, ct});
        exp_dir = d;
        nrows = m[4:3] == ARR_SINGLE ? 2'h0 : 2'h1;
        wait_dir(d);
        slow <= 1'b1;
        n = line_no + n;
        bus(1'b1, OFS_PERIOD, 32'h0000_00C8);
        for (k = 0; k < 60000 && line_no < n; k++) @(negedge core_clk);
        if (line_no < n) hang();
        stop();
        slow <= 1'b0;
    endtask
    // Reset values, ceilings, direction sources, rates, rows
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(OFS_CTRL, CTRL_RESET);
        rd(OFS_MODE, MODE_RESET);
        rd(OFS_PERIOD, PERIOD_RESET);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, OFS_MODE, {22'h0, LM[i]});
            bus(1'b1, OFS_LIMIT, 32'hFFFF_FFFF);
            e = {10'h0, 10'(LK[i]), 12'((CLK_KHZ + LK[i] - 1) / LK[i])};
            rd(OFS_LIMIT, e);
        end
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, OFS_CTRL, {23'h0, DT[i][8:0]});
            dir_line_in <= DT[i][9];
            wheel_dir_in <= DT[i][10];
            wait_dir(DT[i][11]);
        end
        run_rows(10'h000, 10'h100, 1'b0, 130);
        bus(1'b1, OFS_PERIOD, 32'h0000_005A);
        gap(c);
        gap(c);
        chk_reg(32'(c), 32'h0000_005A);
        bus(1'b1, OFS_PERIOD, 32'h0000_0019);
        repeat (300) @(negedge core_clk);
        gap(c);
        chk_reg(32'(c), 32'h0000_0064);
        rd(OFS_MEAS, 32'h0000_0004);
        stop();
        run_rows(10'h008, 10'h100, 1'b0, 20);
        run_rows(10'h008, 10'h140, 1'b1, 20);
        run_rows(10'h010, 10'h140, 1'b1, 20);
        bus(1'b1, OFS_CTRL, 32'h0000_0142);
        gap(c);
        chk_reg(32'(c), 32'h0000_00FF);
        final_report();
    end
endmodule
`default_nettype wire

/* testbench/lrsd_fg_model.sv */
// Frame grabber stand-in: takes row tags and sorts them into planes.
// A random coin from the bench stalls it while slow.
`timescale 1ns/100ps
`default_nettype none
module lrsd_fg_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic coin,
    input wire logic row_valid,
    input wire logic [lrsd_pkg::TAG_W-1:0] row_tag,
    output logic row_ready
);
    int plane_rows [4];
    // A busy grabber drops ready at random; the buffer must hold
    always @(posedge core_clk) begin
        row_ready <= reset_n && !(slow && coin);
    end
    // All alignment storage lives here, one plane per array index
    always @(posedge core_clk) begin
        if (reset_n && row_valid && row_ready) begin
            plane_rows[row_tag[30:29]] <= plane_rows[row_tag[30:29]] + 1;
        end
    end
endmodule
`default_nettype wire

/* testbench/lrsd_monitor.sv */
// Port checks for the line rate and scan direction controller.
// Bound into lrsd_ctrl; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module lrsd_monitor (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic line_trigger,
    input wire logic scan_reverse,
    input wire logic row_valid,
    input wire logic row_ready,
    input wire logic [lrsd_pkg::TAG_W-1:0] row_tag
);
    import lrsd_pkg::*;
    // One domain; quiet in reset
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    AST_BUS_ONE_WAIT: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wrong wait state count");
    AST_TRIG_SPACING: assert property (
        line_trigger |=> !line_trigger [*8])
        else $error("triggers closer than any cap");
    AST_ROW_LATENCY: assert property (
        line_trigger && !row_valid |-> ##2 row_valid)
        else $error("row late after trigger");
    AST_ROW_HOLD: assert property (
        row_valid && !row_ready |=> row_valid && $stable(row_tag))
        else $error("stalled row changed");
    AST_MAIN_OFFSET: assert property (
        row_valid && row_tag[30:29] == 2'h0 |-> row_tag[27:18] == 10'h000)
        else $error("main row offset nonzero");
    AST_DUAL_OFFSET: assert property (
        row_valid && row_tag[30:29] == 2'h1 |->
        row_tag[27:18] == (row_tag[31] ? SPACE_REV : SPACE_FWD))
        else $error("secondary offset wrong");
    AST_SPATIAL_FLAG: assert property (
        row_valid |-> row_tag[28] == (row_tag[17:16] != 2'h0))
        else $error("spatial flag wrong");
    AST_ARRAY_ORDER: assert property (
        row_valid |-> row_tag[30:29] <= row_tag[17:16])
        else $error("array index too high");
    AST_DIR_AT_LINE: assert property (
        $changed(scan_reverse) |-> !$past(line_trigger))
        else $error("direction changed at accept");
endmodule
bind lrsd_ctrl lrsd_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .line_trigger(line_trigger), .scan_reverse(scan_reverse), .row_valid(row_valid),
    .row_ready(row_ready), .row_tag(row_tag));
`default_nettype wire
